// >>> hdl/ivte_top.sv
// What this block does
// - Each source owns a request flag, an enable flag and a vector at its trap number times four.
// - Sources cover trap numbers 10h..47h, the shared extension vectors sitting at 40h..43h from 100h.
// - A hardware trap is taken at once, unmaskable, through its own vector like an interrupt entry.
// - Every hardware trap also sets its own bit in the trap indication register.
// - A trap preempts anything except an active trap service of equal or higher rank, behind which it waits.
// - During a trap service, neither standard interrupts nor event transfers are granted.
// - Each source has one of sixteen levels and only a strictly higher level interrupts a service.
// - A routed source costs one transfer cycle per request, and vectors when its channel count hits zero.
//
// Local design decisions: the APB register port and the register offsets.
`default_nettype none
module ivte_top
    import ivte_pkg::*;
#(
    parameter int NUM_SRC = IVTE_NUM_SRC,
    parameter int NUM_CH  = 8,
    parameter int CNT_W   = 8
) (
    input  wire logic                   clk,
    input  wire logic                   rst_b,
    input  wire logic [IVTE_ADDR_W-1:0] paddr,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic [NUM_SRC-1:0]     src_evt,
    input  wire logic [3:0]             trap_evt,
    output logic                        vec_req,
    output logic                        vec_is_trap,
    output logic      [6:0]             vec_trap,
    output logic      [IVTE_VEC_W-1:0]  vec_addr,
    input  wire logic                   vec_ack,
    input  wire logic                   svc_return,
    input  wire logic [3:0]             ret_prio,
    output logic                        xfer_req,
    output logic      [2:0]             xfer_chan,
    input  wire logic                   xfer_ack,
    output logic      [3:0]             cpu_prio,
    output logic                        trap_active,
    output logic                        irq
);
    // Elaboration check: trap numbers must stay within 7 bits and channels within 3
    if (NUM_SRC < 1 || NUM_SRC > 56 || NUM_CH < 1 || NUM_CH > 8 || CNT_W < 1 || CNT_W > 16) begin : g_bad_param
        $error("ivte_top parameter out of range");
    end

    localparam int SW = $clog2(NUM_SRC + 1);

    // Reset release through two flops
    logic rst_s1_q, rst_sync_b;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_q   <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_s1_q   <= 1'b1;
            rst_sync_b <= rst_s1_q;
        end
    end

    // State
    ivte_state_t            state_q;
    logic [3:0]             lvl_q   [NUM_SRC];
    logic [NUM_SRC-1:0]     ie_q, ir_q, route_q;
    logic [2:0]             chan_q  [NUM_SRC];
    logic [CNT_W-1:0]       cnt_q   [NUM_CH];
    logic [3:0]             tir_q, tpend_q;
    logic [IVTE_NUM_EV-1:0] ist_q, imsk_q;
    logic [3:0]             prio_q;
    logic [1:0]             rank_q, rank_prev_q, sel_rank_q;
    logic [SW-1:0]          sel_idx_q;
    logic [1:0]             sel_tbit_q;
    logic [31:0]            rdata_q;
    logic                   err_q;

    // APB decode: setup captures read data, access completes with no wait
    wire             setup   = psel & ~penable;
    wire             wr_acc  = psel & penable & pwrite;
    wire [9:0]       widx    = paddr[11:2];
    wire             is_ctrl = (paddr < IVTE_CTRL_BASE + 12'(4 * NUM_SRC)) && (paddr[1:0] == 2'b00);
    wire             is_cnt  = (paddr >= IVTE_CNT_BASE) && (paddr < IVTE_CNT_BASE + 12'(4 * NUM_CH))
                               && (paddr[1:0] == 2'b00);
    wire [SW-1:0]    cidx    = SW'(widx);
    wire [2:0]       nidx    = 3'(widx - 10'(IVTE_CNT_BASE >> 2));
    wire             wr_tir  = wr_acc && paddr == IVTE_TIR_OFF;
    wire             wr_ist  = wr_acc && paddr == IVTE_IST_OFF;
    wire             wr_msk  = wr_acc && paddr == IVTE_IMSK_OFF;
    wire             wr_prio = wr_acc && paddr == IVTE_PRIO_OFF;
    wire             mapped  = is_ctrl | is_cnt | paddr == IVTE_TIR_OFF | paddr == IVTE_IST_OFF
                               | paddr == IVTE_IMSK_OFF | paddr == IVTE_PRIO_OFF | paddr == IVTE_STATE_OFF;
    assign pready  = psel & penable;
    assign prdata  = rdata_q;
    assign pslverr = err_q;

    // Read mux
    logic [31:0] rmux;
    always_comb begin
        rmux = 32'h0000_0000;
        if (is_ctrl)
            rmux = 32'({chan_q[cidx], route_q[cidx], ir_q[cidx], ie_q[cidx], 2'b00, lvl_q[cidx]});
        else if (is_cnt)
            rmux = 32'(cnt_q[nidx]);
        else if (paddr == IVTE_TIR_OFF)
            rmux = 32'(tir_q);
        else if (paddr == IVTE_IST_OFF)
            rmux = 32'(ist_q);
        else if (paddr == IVTE_IMSK_OFF)
            rmux = 32'(imsk_q);
        else if (paddr == IVTE_PRIO_OFF)
            rmux = 32'(prio_q);
        else if (paddr == IVTE_STATE_OFF)
            rmux = 32'({rank_q, tpend_q, 2'(state_q)});
    end

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            rdata_q <= 32'h0000_0000;
            err_q   <= 1'b0;
        end else if (setup) begin
            rdata_q <= pwrite ? 32'h0000_0000 : rmux;
            err_q   <= ~mapped;
        end
    end

    // Interrupt arbitration: highest enabled level above the CPU level, lowest index on ties
    logic          best_ok;
    logic [SW-1:0] best_idx;
    logic [3:0]    best_lvl;
    always_comb begin
        best_ok  = 1'b0;
        best_idx = '0;
        best_lvl = 4'h0;
        for (int k = 0; k < NUM_SRC; k++) begin
            if (ir_q[k] && ie_q[k] && lvl_q[k] > prio_q
                && (!best_ok || lvl_q[k] > best_lvl)) begin
                best_ok  = 1'b1;
                best_idx = SW'(k);
                best_lvl = lvl_q[k];
            end
        end
    end

    // Trap selection: class A in fixed order, then class B
    wire [1:0] tsel_bit  = tpend_q[IVTE_T_NMI]   ? 2'(IVTE_T_NMI)   :
                           tpend_q[IVTE_T_STKOF] ? 2'(IVTE_T_STKOF) :
                           tpend_q[IVTE_T_STKUF] ? 2'(IVTE_T_STKUF) : 2'(IVTE_T_CLASSB);
    wire [1:0] tsel_rank = (tpend_q[2:0] != 3'b000) ? IVTE_RANK_A :
                           (tpend_q[IVTE_T_CLASSB] ? IVTE_RANK_B : 2'h0);
    wire       trap_go   = tsel_rank > rank_q;
    wire [6:0] tsel_tn   = tsel_bit == 2'(IVTE_T_NMI)   ? IVTE_TN_NMI   :
                           tsel_bit == 2'(IVTE_T_STKOF) ? IVTE_TN_STKOF :
                           tsel_bit == 2'(IVTE_T_STKUF) ? IVTE_TN_STKUF : IVTE_TN_CLASSB;
    wire       int_go    = best_ok && rank_q == 2'h0;
    wire       use_xfer  = route_q[best_idx] && cnt_q[chan_q[best_idx]] != '0;
    wire [6:0] src_tn    = IVTE_FIRST_TRAP + 7'(best_idx);

    // Completion strobes
    wire vec_done   = state_q == IVTE_VEC_WAIT && vec_ack;
    wire xfer_done  = state_q == IVTE_XFER_WAIT && xfer_ack;
    wire trap_taken = vec_done && vec_is_trap;
    wire int_taken  = vec_done && !vec_is_trap;
    wire cnt_last   = xfer_done && cnt_q[xfer_chan] == CNT_W'(1);

    // Sequencer handshake state machine
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            state_q     <= IVTE_IDLE;
            vec_is_trap <= 1'b0;
            vec_trap    <= 7'h00;
            vec_addr    <= '0;
            xfer_chan   <= 3'h0;
            sel_idx_q   <= '0;
            sel_tbit_q  <= 2'h0;
            sel_rank_q  <= 2'h0;
        end else begin
            unique case (state_q)
                IVTE_IDLE: begin
                    if (trap_go) begin
                        state_q     <= IVTE_VEC_WAIT;
                        vec_is_trap <= 1'b1;
                        vec_trap    <= tsel_tn;
                        vec_addr    <= ivte_vec_of(tsel_tn);
                        sel_tbit_q  <= tsel_bit;
                        sel_rank_q  <= tsel_rank;
                    end else if (int_go) begin
                        sel_idx_q   <= best_idx;
                        vec_is_trap <= 1'b0;
                        vec_trap    <= src_tn;
                        vec_addr    <= ivte_vec_of(src_tn);
                        xfer_chan   <= chan_q[best_idx];
                        state_q     <= use_xfer ? IVTE_XFER_WAIT : IVTE_VEC_WAIT;
                    end
                end
                IVTE_VEC_WAIT:  if (vec_ack) state_q <= IVTE_IDLE;
                IVTE_XFER_WAIT: if (xfer_ack) state_q <= IVTE_IDLE;
            endcase
        end
    end
    assign vec_req  = state_q == IVTE_VEC_WAIT;
    assign xfer_req = state_q == IVTE_XFER_WAIT;

    // CPU level and trap service nesting
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            prio_q      <= IVTE_PRIO_RST;
            rank_q      <= 2'h0;
            rank_prev_q <= 2'h0;
        end else if (trap_taken) begin
            prio_q      <= IVTE_TOP_PRIO;
            rank_prev_q <= rank_q;
            rank_q      <= sel_rank_q;
        end else if (int_taken) begin
            prio_q      <= lvl_q[sel_idx_q];
        end else if (svc_return) begin
            prio_q      <= ret_prio;
            rank_q      <= rank_prev_q;
            rank_prev_q <= 2'h0;
        end else if (wr_prio) begin
            prio_q      <= pwdata[3:0];
        end
    end
    assign cpu_prio    = prio_q;
    assign trap_active = rank_q != 2'h0;

    // Trap pending and indication bits: a new trap wins over any clear
    wire [3:0] tclr = trap_taken ? 4'(1) << sel_tbit_q : 4'h0;
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            tpend_q <= 4'h0;
            tir_q   <= 4'h0;
        end else begin
            tpend_q <= trap_evt | (tpend_q & ~tclr);
            tir_q   <= trap_evt | (tir_q & ~(wr_tir ? pwdata[3:0] : 4'h0));
        end
    end

    // Per-source control words
    for (genvar k = 0; k < NUM_SRC; k++) begin : g_src
        wire wr_k  = wr_acc && is_ctrl && cidx == SW'(k);
        wire hclr  = sel_idx_q == SW'(k) && (int_taken || (xfer_done && !cnt_last));
        always_ff @(posedge clk or negedge rst_sync_b) begin
            if (!rst_sync_b) begin
                lvl_q[k]   <= IVTE_CTRL_RST[3:0];
                ie_q[k]    <= IVTE_CTRL_RST[IVTE_IE_BIT];
                ir_q[k]    <= IVTE_CTRL_RST[IVTE_IR_BIT];
                route_q[k] <= IVTE_CTRL_RST[IVTE_ROUTE_BIT];
                chan_q[k]  <= IVTE_CTRL_RST[IVTE_CHAN_LSB +: 3];
            end else begin
                ir_q[k] <= src_evt[k] | (!hclr && (wr_k ? pwdata[IVTE_IR_BIT] : ir_q[k]));
                if (wr_k) begin
                    lvl_q[k]   <= pwdata[IVTE_LVL_LSB +: 4];
                    ie_q[k]    <= pwdata[IVTE_IE_BIT];
                    route_q[k] <= pwdata[IVTE_ROUTE_BIT];
                    chan_q[k]  <= pwdata[IVTE_CHAN_LSB +: 3];
                end
            end
        end
    end

    // Transfer counters: one decrement per transfer
    for (genvar c = 0; c < NUM_CH; c++) begin : g_cnt
        always_ff @(posedge clk or negedge rst_sync_b) begin
            if (!rst_sync_b)
                cnt_q[c] <= '0;
            else if (xfer_done && xfer_chan == 3'(c))
                cnt_q[c] <= cnt_q[c] - CNT_W'(1);
            else if (wr_acc && is_cnt && nidx == 3'(c))
                cnt_q[c] <= pwdata[CNT_W-1:0];
        end
    end

    // Interrupt status, mask and output
    wire [IVTE_NUM_EV-1:0] ev = {vec_done, cnt_last, trap_taken};
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            ist_q  <= '0;
            imsk_q <= IVTE_MASK_RST;
        end else begin
            ist_q <= ev | (ist_q & ~(wr_ist ? pwdata[IVTE_NUM_EV-1:0] : '0));
            if (wr_msk)
                imsk_q <= pwdata[IVTE_NUM_EV-1:0];
        end
    end
    assign irq = |(ist_q & imsk_q);
endmodule
`default_nettype wire

// >>> pkg/ivte_pkg.sv
`default_nettype none
package ivte_pkg;
    // Source table: source k has trap number FIRST_TRAP + k, vector = trap * 4
    localparam int          IVTE_NUM_SRC    = 56;
    localparam logic [6:0]  IVTE_FIRST_TRAP = 7'h10;
    localparam logic [6:0]  IVTE_EXT_TRAP   = 7'h40;   // Shared extension vectors 40h..43h
    localparam int          IVTE_VEC_W      = 9;
    localparam int          IVTE_ADDR_W     = 12;

    // Per-source control word layout
    localparam int          IVTE_LVL_LSB    = 0;
    localparam int          IVTE_IE_BIT     = 6;
    localparam int          IVTE_IR_BIT     = 7;
    localparam int          IVTE_ROUTE_BIT  = 8;
    localparam int          IVTE_CHAN_LSB   = 9;

    // Register offsets (byte addresses)
    localparam logic [11:0] IVTE_CTRL_BASE  = 12'h000;
    localparam logic [11:0] IVTE_CNT_BASE   = 12'h100;
    localparam logic [11:0] IVTE_TIR_OFF    = 12'h140;
    localparam logic [11:0] IVTE_IST_OFF    = 12'h144;
    localparam logic [11:0] IVTE_IMSK_OFF   = 12'h148;
    localparam logic [11:0] IVTE_PRIO_OFF   = 12'h14C;
    localparam logic [11:0] IVTE_STATE_OFF  = 12'h150;

    // Hardware traps: bit positions in trap_indication_register and trap numbers
    localparam int          IVTE_T_NMI      = 0;
    localparam int          IVTE_T_STKOF    = 1;
    localparam int          IVTE_T_STKUF    = 2;
    localparam int          IVTE_T_CLASSB   = 3;
    localparam logic [6:0]  IVTE_TN_NMI     = 7'h02;
    localparam logic [6:0]  IVTE_TN_STKOF   = 7'h04;
    localparam logic [6:0]  IVTE_TN_STKUF   = 7'h06;
    localparam logic [6:0]  IVTE_TN_CLASSB  = 7'h0A;
    localparam logic [1:0]  IVTE_RANK_A     = 2'h2;
    localparam logic [1:0]  IVTE_RANK_B     = 2'h1;
    localparam logic [3:0]  IVTE_TOP_PRIO   = 4'hF;

    // Status events
    localparam int          IVTE_EV_TRAP    = 0;
    localparam int          IVTE_EV_CNTZ    = 1;
    localparam int          IVTE_EV_VEC     = 2;
    localparam int          IVTE_NUM_EV     = 3;

    // Reset values
    localparam logic [11:0] IVTE_CTRL_RST   = 12'h000;
    localparam logic [2:0]  IVTE_MASK_RST   = 3'h0;
    localparam logic [3:0]  IVTE_PRIO_RST   = 4'h0;

    typedef enum logic [1:0] {IVTE_IDLE, IVTE_VEC_WAIT, IVTE_XFER_WAIT} ivte_state_t;

    // Vector location of a trap number
    function automatic logic [8:0] ivte_vec_of(input logic [6:0] tn);
        return {tn, 2'b00};
    endfunction
endpackage
`default_nettype wire

// >>> tb/ivte_asserts.sv
`default_nettype none
module ivte_asserts
    import ivte_pkg::*;
(
    input wire logic                  clk,
    input wire logic                  rst_b,
    input wire logic [3:0]            trap_evt,
    input wire logic                  vec_req,
    input wire logic                  vec_is_trap,
    input wire logic [6:0]            vec_trap,
    input wire logic [IVTE_VEC_W-1:0] vec_addr,
    input wire logic                  vec_ack,
    input wire logic                  xfer_req,
    input wire logic [2:0]            xfer_chan,
    input wire logic                  xfer_ack,
    input wire logic [3:0]            cpu_prio,
    input wire logic                  trap_active
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // Vector location, source range and handshake holding
    chk_vec_addr: assert property (vec_req |-> vec_addr == {vec_trap, 2'b00})
        else $error("vector address is not trap number times four");
    chk_src_range: assert property (vec_req && !vec_is_trap |-> vec_trap >= 7'h10 && vec_trap <= 7'h47)
        else $error("interrupt trap number outside source table");
    chk_vec_hold: assert property (vec_req && !vec_ack |=> vec_req && $stable(vec_addr) && $stable(vec_trap))
        else $error("vector request changed before acknowledge");
    chk_ack_drop: assert property (vec_req && vec_ack |=> !vec_req)
        else $error("vector request stayed after acknowledge");
    chk_xfer_hold: assert property (xfer_req && !xfer_ack |=> xfer_req && $stable(xfer_chan))
        else $error("transfer request changed before acknowledge");
    // Trap entry is quick and forces the top level
    chk_trap_fast: assert property (trap_evt[IVTE_T_NMI] && !vec_req && !xfer_req && !trap_active
        |-> ##[1:2] vec_req && vec_is_trap && vec_trap == IVTE_TN_NMI)
        else $error("trap vector not raised promptly");
    chk_trap_entry: assert property (vec_req && vec_ack && vec_is_trap
        |=> trap_active && cpu_prio == IVTE_TOP_PRIO)
        else $error("trap entry did not raise level to top");
    // Nothing but traps is granted during a trap service; an interrupt entry raises the level
    chk_trap_no_irq: assert property (trap_active && vec_req |-> vec_is_trap)
        else $error("interrupt vector granted during trap service");
    chk_trap_no_xfer: assert property (trap_active && !xfer_req |=> !xfer_req)
        else $error("transfer granted during trap service");
    chk_irq_higher: assert property (vec_req && vec_ack && !vec_is_trap |=> cpu_prio > $past(cpu_prio))
        else $error("interrupt entered without higher level");
endmodule

bind ivte_top ivte_asserts u_ivte_asserts (.clk, .rst_b, .trap_evt, .vec_req, .vec_is_trap, .vec_trap,
    .vec_addr, .vec_ack, .xfer_req, .xfer_chan, .xfer_ack, .cpu_prio, .trap_active);
`default_nettype wire

// >>> tb/ivte_core_model.sv
`default_nettype none
module ivte_core_model (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic [3:0] lat,
    input  wire logic       vec_req,
    input  wire logic       xfer_req,
    output logic            vec_ack,
    output logic            xfer_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] vcnt_q;
    logic [3:0] xcnt_q;

    // Sequencer answers after lat waiting cycles with a one-cycle acknowledge
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            vec_ack  <= 1'b0;
            xfer_ack <= 1'b0;
            vcnt_q   <= 4'h0;
            xcnt_q   <= 4'h0;
        end else begin
            vec_ack  <= vec_req && !vec_ack && vcnt_q >= lat;
            xfer_ack <= xfer_req && !xfer_ack && xcnt_q >= lat;
            vcnt_q   <= (vec_req && !vec_ack) ? vcnt_q + 4'h1 : 4'h0;
            xcnt_q   <= (xfer_req && !xfer_ack) ? xcnt_q + 4'h1 : 4'h0;
        end
    end
endmodule
`default_nettype wire

// >>> tb/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import ivte_pkg::*;
    logic        clk, pready, pslverr, vec_req, vec_is_trap, vec_ack, xfer_req, xfer_ack, trap_active, irq, rerr;
    logic        rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, svc_return = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic [55:0] src_evt = '0;
    logic [3:0]  trap_evt = 4'h0, ret_prio = 4'h0, lat = 4'h0, cpu_prio;
    logic [6:0]  vec_trap;
    logic [8:0]  vec_addr;
    logic [2:0]  xfer_chan;
    int          failures, cmp_count, k, lv, c;
    int          corner[4] = '{6, 48, 51, 55};

    ivte_top #(.NUM_SRC(56)) u_ivte_top (.clk, .rst_b, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .src_evt, .trap_evt, .vec_req, .vec_is_trap, .vec_trap, .vec_addr, .vec_ack,
        .svc_return, .ret_prio, .xfer_req, .xfer_chan, .xfer_ack, .cpu_prio, .trap_active, .irq);
    ivte_core_model u_ivte_core_model (.clk, .rst_b, .lat, .vec_req, .xfer_req, .vec_ack, .xfer_ack);

    // Free running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic wrap_up;
        $display("failures=%0d comparisons=%0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    // Expected control word and trap numbers
    function automatic logic [31:0] cw(input int lvl, ie, ir, rt, ch);
        return 32'(lvl | (ie << IVTE_IE_BIT) | (ir << IVTE_IR_BIT) | (rt << IVTE_ROUTE_BIT) | (ch << IVTE_CHAN_LSB));
    endfunction
    function automatic logic [6:0] tn(input int b);
        return b == 0 ? IVTE_TN_NMI : b == 1 ? IVTE_TN_STKOF : b == 2 ? IVTE_TN_STKUF : IVTE_TN_CLASSB;
    endfunction
    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        psel    <= 1'b1;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            failures++;
            $display("MISMATCH pready expected 1 seen timeout");
            wrap_up();
        end
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // Idle edge so the next setup never reassigns psel in the same time step
        @(posedge clk);
    endtask
    // Bounded wait for a request level on vector (x=0) or transfer (x=1)
    task automatic wt(input bit x, input logic lvl);
        int n;
        n = 0;
        lat <= 4'($urandom_range(0, 3));
        while ((x ? xfer_req : vec_req) !== lvl && n < 40) begin
            @(posedge clk);
            n++;
        end
        if (n >= 40) begin
            failures++;
            $display("MISMATCH request_wait expected %b seen timeout", lvl);
            wrap_up();
        end
    endtask
    task automatic take(input logic [6:0] t, input logic tr);
        wt(0, 1'b1);
        chk("vec_trap", t, vec_trap);
        chk("vec_addr", {t, 2'b00}, vec_addr);
        chk("vec_is_trap", tr, vec_is_trap);
        wt(0, 1'b0);
    endtask
    task automatic quiet(input int n);
        repeat (n) begin
            @(posedge clk);
            chk("vec_req_idle", 0, vec_req);
        end
    endtask
    task automatic pulse(input bit t, input int i);
        if (t) trap_evt <= 4'h1 << i;
        else src_evt <= 56'h1 << i;
        @(posedge clk);
        trap_evt <= 4'h0;
        src_evt  <= '0;
    endtask
    task automatic ret(input logic [3:0] p);
        svc_return <= 1'b1;
        ret_prio   <= p;
        @(posedge clk);
        svc_return <= 1'b0;
        @(posedge clk);
    endtask

    initial begin
        void'($urandom(32'hCB4D));
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        apb(0, IVTE_PRIO_OFF, 0);
        chk("prio_rst", 32'(IVTE_PRIO_RST), rdat);
        chk("mapped_ok", 0, rerr);
        apb(0, 12'hFFC, 0);
        chk("unmapped_err", 1, rerr);
        apb(1, IVTE_IMSK_OFF, 32'h4);
        // Sources: flag held while disabled, level compare, vector location
        for (int i = 0; i < 8; i++) begin
            k  = i < 4 ? corner[i] : $urandom_range(0, 55);
            lv = $urandom_range(1, 15);
            apb(1, IVTE_PRIO_OFF, lv);
            apb(1, 12'(4 * k), cw(lv, 0, 0, 0, 0));
            pulse(0, k);
            quiet(4);
            apb(0, 12'(4 * k), 0);
            chk("req_flag", cw(lv, 0, 1, 0, 0), rdat);
            apb(1, 12'(4 * k), cw(lv, 1, 1, 0, 0));
            quiet(4);
            apb(1, IVTE_PRIO_OFF, lv - 1);
            take(IVTE_FIRST_TRAP + 7'(k), 1'b0);
            chk("cpu_prio", lv, cpu_prio);
            chk("irq_set", 1, irq);
            apb(1, IVTE_IMSK_OFF, 32'h0);
            @(posedge clk);
            chk("irq_masked", 0, irq);
            apb(1, IVTE_IMSK_OFF, 32'h4);
            apb(1, IVTE_IST_OFF, 32'h4);
            @(posedge clk);
            chk("irq_clear", 0, irq);
            ret(4'h0);
            apb(0, 12'(4 * k), 0);
            chk("req_taken", cw(lv, 1, 0, 0, 0), rdat);
        end
        // Every hardware trap: vector, indication bit, blocking of interrupts
        apb(1, 12'h00C, cw(5, 1, 0, 0, 0));
        for (int b = 0; b < 4; b++) begin
            pulse(1, b);
            take(tn(b), 1'b1);
            chk("trap_active", 1, trap_active);
            apb(0, IVTE_TIR_OFF, 0);
            chk("trap_ind", 32'h1 << b, rdat);
            apb(1, IVTE_TIR_OFF, 32'h1 << b);
            pulse(0, 3);
            quiet(6);
            ret(4'h0);
            chk("trap_end", 0, trap_active);
            take(7'h13, 1'b0);
            ret(4'h0);
        end
        // Trap ranking: class B waits behind class A, class A preempts class B
        pulse(1, IVTE_T_NMI);
        take(IVTE_TN_NMI, 1'b1);
        pulse(1, IVTE_T_CLASSB);
        quiet(6);
        ret(4'h0);
        take(IVTE_TN_CLASSB, 1'b1);
        pulse(1, IVTE_T_STKOF);
        take(IVTE_TN_STKOF, 1'b1);
        ret(4'hF);
        ret(4'h0);
        apb(1, IVTE_TIR_OFF, 32'hF);
        // Routed source: one transfer per event, vector when the count ends
        c = $urandom_range(0, 7);
        apb(1, IVTE_CNT_BASE + 12'(4 * c), 32'h2);
        apb(1, 12'h024, cw(6, 1, 0, 1, c));
        repeat (2) begin
            pulse(0, 9);
            wt(1, 1'b1);
            chk("xfer_chan", c, xfer_chan);
            chk("no_vector", 0, vec_req);
            wt(1, 1'b0);
        end
        take(7'h19, 1'b0);
        apb(0, IVTE_IST_OFF, 0);
        chk("cnt_zero_evt", 1, rdat[IVTE_EV_CNTZ]);
        apb(0, IVTE_CNT_BASE + 12'(4 * c), 0);
        chk("count", 0, rdat);
        ret(4'h0);
        wrap_up();
    end
endmodule
`default_nettype wire
